// ---- core/scg_access_chk.sv ----
// access checker: answers each peripheral access with ok or bus fault one cycle later
// assumes acc_valid is a one-cycle pulse on core_clk
`timescale 1ns/1ps
module scg_access_chk
(
	input  wire logic                       core_clk,
	input  wire logic                       rst_n,
	scg_gate_if.chk                         gif,
	input  wire logic                       acc_valid,
	input  wire logic [scg_pkg::UNIT_W-1:0] acc_unit,
	output logic                            acc_ok_q,
	output logic                            acc_fault_q
);

	wire known;
	wire clocked;

	// an index past the last unit has no clock at all and faults as well
	assign known   = acc_unit < scg_pkg::UNIT_W'(scg_pkg::NUM_UNITS);
	assign clocked = known && gif.unit_en[acc_unit];

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			acc_ok_q    <= 1'b0;
			acc_fault_q <= 1'b0;
		end
		else
		begin
			acc_ok_q    <= acc_valid && clocked;
			acc_fault_q <= acc_valid && !clocked; // [RULE_02]
		end
	end

endmodule

// ---- core/scg_gate_sel.sv ----
// per-unit clock enable selection from the run or sleep gate word
// assumes the gate words come from registers on the same clock
`timescale 1ns/1ps
module scg_gate_sel
(
	scg_gate_if.sel gif
);

	wire use_sleep;

	// sleep word only when asleep and automatic gating is chosen [RULE_12] [RULE_14]
	assign use_sleep = (gif.mode == scg_pkg::SCG_MODE_SLEEP) && gif.auto_sel;

	genvar u;
	generate
		for (u = 0; u < scg_pkg::NUM_UNITS; u++)
		begin : g_unit
			assign gif.unit_en[u] = use_sleep ? gif.sleep_gate[scg_pkg::UNIT_BIT[u]]
			                                  : gif.run_gate[scg_pkg::UNIT_BIT[u]]; // [RULE_01]
		end
	endgenerate

endmodule

// ---- core/scg_top.sv ----
// sleep-mode peripheral clock gating: gate register, mode selection, access fault reporting
// assumes a plain register port on core_clk; sleep state and run gate word come from logic on core_clk
//
// Summary of operation
// RULE_01: a set enable bit clocks its unit, a clear one stops the clock and disables the unit.
// RULE_02: an access to a unit whose clock is off is answered with a bus fault.
// RULE_03: after reset the sleep gate register reads 0x00000000, so every unit is unclocked.
// RULE_04: software sets the bit of every unit it needs while asleep.
// RULE_05: the register sits at offset 0x114 of the system-control base 0x400F.E000 and its bits are read-write.
// RULE_06: timer gates three to zero are bits 19 to 16.
// RULE_07: two-wire unit one is bit 14 and unit zero is bit 12.
// RULE_08: the quadrature encoder gate is bit 8.
// RULE_09: synchronous serial unit one is bit 5 and unit zero is bit 4.
// RULE_10: UART gates two, one and zero are bits 2, 1 and 0.
// RULE_11: software ignores reserved bits and writes back what it read.
// RULE_12: this register governs the clocks only while automatic gating is selected.
// RULE_13: reserved bits read zero and ignore writes.
// RULE_14: in sleep with automatic gating the enables follow this register, otherwise the run word.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
module scg_top
(
	input  wire logic                        core_clk,
	input  wire logic                        rst_n,
	input  wire logic [scg_pkg::ADDR_W-1:0]  reg_addr,
	input  wire logic [31:0]                 reg_wdata,
	input  wire logic                        reg_wr,
	input  wire logic                        reg_rd,
	output logic      [31:0]                 reg_rdata_q,
	input  wire logic                        sleep_active,
	input  wire logic [31:0]                 run_peripheral_clock_gate,
	input  wire logic                        acc_valid,
	input  wire logic [scg_pkg::UNIT_W-1:0]  acc_unit,
	output logic                             acc_ok_q,
	output logic                             acc_fault_q,
	output logic      [scg_pkg::NUM_UNITS-1:0] periph_clk_en_q,
	output logic                             irq_q
);

	// ****************************************************************
	// registers and decode
	// ****************************************************************
	logic [31:0]               sleep_gate_q;
	logic [31:0]               gate_ctrl_q;
	logic [scg_pkg::IRQ_W-1:0] irq_status_q;
	logic [scg_pkg::IRQ_W-1:0] irq_enable_q;
	logic [scg_pkg::IRQ_W-1:0] irq_status_d;
	logic [scg_pkg::IRQ_W-1:0] irq_event;
	logic [31:0]               rdata_d;

	wire sel_sleep  = reg_addr == scg_pkg::OFS_SLEEP_GATE;
	wire sel_ctrl   = reg_addr == scg_pkg::OFS_GATE_CTRL;
	wire sel_status = reg_addr == scg_pkg::OFS_IRQ_STATUS;
	wire sel_enable = reg_addr == scg_pkg::OFS_IRQ_ENABLE;
	wire sel_clear  = reg_addr == scg_pkg::OFS_IRQ_CLEAR;

	scg_gate_if gif ();

	assign gif.sleep_gate = sleep_gate_q;
	assign gif.run_gate   = run_peripheral_clock_gate;
	assign gif.auto_sel   = gate_ctrl_q[scg_pkg::BIT_AUTO_SEL];
	assign gif.mode       = sleep_active ? scg_pkg::SCG_MODE_SLEEP : scg_pkg::SCG_MODE_RUN;

	scg_gate_sel u_sel
	(
		.gif (gif.sel)
	);

	scg_access_chk u_chk
	(
		.core_clk    (core_clk),
		.rst_n       (rst_n),
		.gif         (gif.chk),
		.acc_valid   (acc_valid),
		.acc_unit    (acc_unit),
		.acc_ok_q    (acc_ok_q),
		.acc_fault_q (acc_fault_q)
	);

	// ****************************************************************
	// register writes
	// ****************************************************************
	// mask keeps reserved bits at zero whatever is written [RULE_13]
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sleep_gate_q <= scg_pkg::SLEEP_GATE_RESET; // [RULE_03]
			gate_ctrl_q  <= scg_pkg::GATE_CTRL_RESET;
			irq_enable_q <= scg_pkg::IRQ_RESET;
		end
		else if (reg_wr)
		begin
			if (sel_sleep)
				sleep_gate_q <= reg_wdata & scg_pkg::SLEEP_GATE_MASK; // [RULE_05] [RULE_06] [RULE_07] [RULE_08] [RULE_09] [RULE_10]
			if (sel_ctrl)
				gate_ctrl_q <= reg_wdata & scg_pkg::GATE_CTRL_MASK;
			if (sel_enable)
				irq_enable_q <= reg_wdata[scg_pkg::IRQ_W-1:0];
		end
	end

	// ****************************************************************
	// events and interrupt
	// ****************************************************************
	// a new event beats a clear in the same cycle so none is lost
	assign irq_event[scg_pkg::IRQ_BUS_FAULT]   = acc_fault_q;
	assign irq_event[scg_pkg::IRQ_GATE_CHANGE] = gif.unit_en != periph_clk_en_q;
	assign irq_status_d = (irq_status_q & ~((reg_wr && sel_clear) ? reg_wdata[scg_pkg::IRQ_W-1:0]
	                                                              : scg_pkg::IRQ_RESET)) | irq_event;

	// unmapped reads answer zero; the clear register is write-only
	assign rdata_d = !reg_rd    ? 32'h0000_0000 :
	                 sel_sleep  ? sleep_gate_q :
	                 sel_ctrl   ? gate_ctrl_q :
	                 sel_status ? {30'h0, irq_status_q} :
	                 sel_enable ? {30'h0, irq_enable_q} : 32'h0000_0000;

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			irq_status_q    <= scg_pkg::IRQ_RESET;
			irq_q           <= 1'b0;
			reg_rdata_q     <= 32'h0000_0000;
			periph_clk_en_q <= '0;
		end
		else
		begin
			irq_status_q    <= irq_status_d;
			irq_q           <= |(irq_status_d & irq_enable_q);
			reg_rdata_q     <= rdata_d;
			periph_clk_en_q <= gif.unit_en; // [RULE_01] [RULE_14]
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	wire sleep_sel_now = sleep_active && gate_ctrl_q[scg_pkg::BIT_AUTO_SEL];

	a_gate_follows_sleep: assert property ( // [RULE_14]
		sleep_sel_now |=> periph_clk_en_q[5] == $past(sleep_gate_q[scg_pkg::BIT_QUAD_ENC]))
		else $error("encoder enable does not follow sleep gate");
	a_gate_follows_run: assert property ( // [RULE_12]
		!sleep_sel_now |=> periph_clk_en_q[0] == $past(run_peripheral_clock_gate[scg_pkg::BIT_ASYNC_SER0]))
		else $error("async serial unit 0 enable does not follow run word");
	a_timer_unit3_pos: assert property ( // [RULE_06]
		sleep_sel_now |=> periph_clk_en_q[11] == $past(sleep_gate_q[19]))
		else $error("timer unit 3 gate not at bit 19");
	a_two_wire_pos: assert property ( // [RULE_07]
		sleep_sel_now |=> periph_clk_en_q[7:6] == {$past(sleep_gate_q[14]), $past(sleep_gate_q[12])})
		else $error("two-wire gates misplaced");
	a_sync_ser_pos: assert property ( // [RULE_09]
		sleep_sel_now |=> periph_clk_en_q[4:3] == $past(sleep_gate_q[5:4]))
		else $error("sync serial gates misplaced");
	a_async_ser_pos: assert property ( // [RULE_10]
		sleep_sel_now |=> periph_clk_en_q[2:0] == $past(sleep_gate_q[2:0]))
		else $error("uart gates misplaced");
	a_reserved_zero: assert property ( // [RULE_13]
		(sleep_gate_q & ~scg_pkg::SLEEP_GATE_MASK) == 32'h0000_0000)
		else $error("reserved gate bit set");
	a_write_readback: assert property ( // [RULE_05]
		reg_wr && sel_sleep ##1 reg_rd && sel_sleep && !reg_wr |=>
		reg_rdata_q == ($past(reg_wdata, 2) & scg_pkg::SLEEP_GATE_MASK))
		else $error("sleep gate readback mismatch");
	a_fault_on_gated: assert property ( // [RULE_02]
		acc_valid && acc_unit == 4'h5 && !gif.unit_en[5] |=> acc_fault_q && !acc_ok_q)
		else $error("gated encoder access not faulted");
	a_ok_on_clocked: assert property ( // [RULE_01]
		acc_valid && acc_unit == 4'h8 && gif.unit_en[8] |=> acc_ok_q && !acc_fault_q)
		else $error("clocked timer unit 0 access faulted");
	a_fault_sets_irq: assert property ( // [RULE_02]
		acc_fault_q && irq_enable_q[scg_pkg::IRQ_BUS_FAULT] |=> irq_q)
		else $error("fault did not raise interrupt");
	a_reset_value: assert property ( // [RULE_03]
		$rose(rst_n) |-> sleep_gate_q == scg_pkg::SLEEP_GATE_RESET)
		else $error("gate register not zero after reset");

	c_sleep_gating: cover property (sleep_sel_now ##1 periph_clk_en_q != '0);
	c_bus_fault:    cover property (acc_fault_q);
	c_irq_clear:    cover property (irq_q ##1 reg_wr && sel_clear ##1 !irq_q);
	c_run_to_sleep: cover property (!sleep_active ##1 sleep_sel_now);

endmodule

// ---- inc/scg_gate_if.sv ----
// carrier between the register block, the gate selector and the access checker
// assumes all users sit on one clock; the interface holds no state
`timescale 1ns/1ps
interface scg_gate_if;
	logic [31:0]                   sleep_gate;
	logic [31:0]                   run_gate;
	logic                          auto_sel;
	scg_pkg::scg_mode_e            mode;
	logic [scg_pkg::NUM_UNITS-1:0] unit_en;

	modport ctl (output sleep_gate, output run_gate, output auto_sel, output mode, input unit_en);
	modport sel (input sleep_gate, input run_gate, input auto_sel, input mode, output unit_en);
	modport chk (input unit_en);
endinterface

// ---- inc/scg_pkg.sv ----
// package of the sleep-mode clock gating block: register map, field layout, reset values
// assumes a 32-bit register port with word offsets inside the system-control space
package scg_pkg;

	// ****************************************************************
	// register map
	// ****************************************************************
	localparam logic [31:0] SYSCTL_BASE     = 32'h400f_e000;
	localparam int          ADDR_W          = 12;
	localparam logic [11:0] OFS_SLEEP_GATE  = 12'h114;
	localparam logic [11:0] OFS_GATE_CTRL   = 12'h130;
	localparam logic [11:0] OFS_IRQ_STATUS  = 12'h134;
	localparam logic [11:0] OFS_IRQ_ENABLE  = 12'h138;
	localparam logic [11:0] OFS_IRQ_CLEAR   = 12'h13c;

	// ****************************************************************
	// sleep gate field positions
	// ****************************************************************
	localparam int BIT_GP_TIMER_3  = 19;
	localparam int BIT_GP_TIMER_2  = 18;
	localparam int BIT_GP_TIMER_1  = 17;
	localparam int BIT_GP_TIMER_0  = 16;
	localparam int BIT_TWO_WIRE1   = 14;
	localparam int BIT_TWO_WIRE0   = 12;
	localparam int BIT_QUAD_ENC    = 8;
	localparam int BIT_SYNC_SER1   = 5;
	localparam int BIT_SYNC_SER0   = 4;
	localparam int BIT_ASYNC_SER2  = 2;
	localparam int BIT_ASYNC_SER1  = 1;
	localparam int BIT_ASYNC_SER0  = 0;

	localparam int NUM_UNITS = 12;
	localparam int UNIT_W    = 4;

	// unit index -> gate bit; index order is the order of the clock enable outputs
	localparam int UNIT_BIT [NUM_UNITS] = '{
		BIT_ASYNC_SER0, BIT_ASYNC_SER1, BIT_ASYNC_SER2, BIT_SYNC_SER0,
		BIT_SYNC_SER1,  BIT_QUAD_ENC,   BIT_TWO_WIRE0,  BIT_TWO_WIRE1,
		BIT_GP_TIMER_0, BIT_GP_TIMER_1, BIT_GP_TIMER_2, BIT_GP_TIMER_3};

	localparam logic [31:0] SLEEP_GATE_MASK  = 32'h000f_5137;
	localparam logic [31:0] SLEEP_GATE_RESET = 32'h0000_0000;

	// ****************************************************************
	// control and interrupt fields
	// ****************************************************************
	localparam int          BIT_AUTO_SEL     = 0;
	localparam logic [31:0] GATE_CTRL_MASK   = 32'h0000_0001;
	localparam logic [31:0] GATE_CTRL_RESET  = 32'h0000_0000;
	localparam int          IRQ_W            = 2;
	localparam int          IRQ_BUS_FAULT    = 0;
	localparam int          IRQ_GATE_CHANGE  = 1;
	localparam logic [1:0]  IRQ_RESET        = 2'h0;

	typedef enum logic [0:0] {
		SCG_MODE_RUN   = 1'b0,
		SCG_MODE_SLEEP = 1'b1
	} scg_mode_e;

endpackage

// ---- test/scg_periph_model.sv ----
// partner model: the gated peripheral units, which make accesses and count the clocks they get
// assumes enables and access answers are registered on core_clk
`timescale 1ns/1ps
module scg_periph_model
(
	input  wire logic                          core_clk,
	input  wire logic [scg_pkg::NUM_UNITS-1:0] clk_en,
	input  wire logic                          acc_ok,
	input  wire logic                          acc_fault,
	output logic                               acc_valid,
	output logic      [scg_pkg::UNIT_W-1:0]    acc_unit
);
	int unsigned ticks [scg_pkg::NUM_UNITS];

	initial
	begin
		acc_valid = 1'b0;
		acc_unit  = 4'h0;
		foreach (ticks[i]) ticks[i] = 0;
	end

	// a unit only advances while its clock enable is high
	always @(posedge core_clk)
		foreach (ticks[i]) if (clk_en[i]) ticks[i] <= ticks[i] + 1;

	// the unit lines are inverted when idle, which puts the index past the last unit only for units 0 to 3
	task automatic access(input logic [scg_pkg::UNIT_W-1:0] unit, output logic ok, output logic fault);
		@(posedge core_clk);
		acc_valid <= 1'b1;
		acc_unit  <= unit;
		@(posedge core_clk);
		acc_valid <= 1'b0;
		acc_unit  <= ~unit;
		#1;
		ok    = acc_ok;
		fault = acc_fault;
	endtask
endmodule

// ---- test/scg_top_tb_top.sv ----
// testbench of the sleep-mode clock gating block: register port tasks and directed tests
// assumes the partner model makes the peripheral accesses
`timescale 1ns/1ps
module scg_top_tb_top;
	logic        core_clk;
	logic        rst_n;
	logic [11:0] reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_rdata_q;
	logic        sleep_active;
	logic [31:0] run_gate;
	logic        acc_valid;
	logic [3:0]  acc_unit;
	logic        acc_ok_q;
	logic        acc_fault_q;
	logic [11:0] en_q;
	logic        irq_q;
	logic [31:0] rd;
	logic        ok;
	logic        flt;
	logic [31:0] gate_w;
	int unsigned t0;
	int unsigned t1;
	int          n_mismatch = 0;
	int          num_checks = 0;
	int          bitpos [12] = '{0, 1, 2, 4, 5, 8, 12, 14, 16, 17, 18, 19};

	scg_top u_dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .sleep_active(sleep_active),
		.run_peripheral_clock_gate(run_gate), .acc_valid(acc_valid), .acc_unit(acc_unit),
		.acc_ok_q(acc_ok_q), .acc_fault_q(acc_fault_q), .periph_clk_en_q(en_q), .irq_q(irq_q));
	scg_periph_model u_periph (.core_clk(core_clk), .clk_en(en_q), .acc_ok(acc_ok_q),
		.acc_fault(acc_fault_q), .acc_valid(acc_valid), .acc_unit(acc_unit));

	initial
	begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	// ****************************************************************
	// bus tasks
	// ****************************************************************
	task automatic wr32(input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd32(input logic [11:0] a, output logic [31:0] d);
		@(posedge core_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata_q;
	endtask

	// write then read back with no gap between the strobes
	task automatic wr_rd32(input logic [11:0] a, input logic [31:0] wd, output logic [31:0] d);
		@(posedge core_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= wd;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata_q;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial
	begin
		#20000;
		n_mismatch++;
		end_of_test();
	end

	// ****************************************************************
	// tests
	// ****************************************************************
	initial
	begin
		rst_n = 1'b0;
		reg_addr = 12'h000;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		sleep_active = 1'b0;
		run_gate = 32'h0;
		repeat (8) @(posedge core_clk);
		rst_n <= 1'b1;
		rd32(scg_pkg::OFS_SLEEP_GATE, rd);
		chk(rd, 32'h0000_0000);
		chk({20'h0, en_q}, 32'h0000_0000);
		wr_rd32(scg_pkg::OFS_SLEEP_GATE, 32'hffff_ffff, rd);
		chk(rd, 32'h000f_5137);
		$display("test reset_and_access done");
		sleep_active <= 1'b1;
		wr32(scg_pkg::OFS_GATE_CTRL, 32'h1);
		gate_w = 32'h000f_5137;
		for (int i = 0; i < 12; i++)
		begin
			rd32(scg_pkg::OFS_SLEEP_GATE, rd);
			chk(rd, gate_w);
			gate_w = (rd & 32'hfff0_aec8) | (32'h1 << bitpos[i]);
			wr32(scg_pkg::OFS_SLEEP_GATE, gate_w);
			cyc(2);
			chk({20'h0, en_q}, 32'h1 << i);
			t0 = u_periph.ticks[i];
			t1 = u_periph.ticks[(i + 1) % 12];
			u_periph.access(4'(i), ok, flt);
			chk({30'h0, ok, flt}, 32'h2);
			u_periph.access(4'((i + 1) % 12), ok, flt);
			chk({30'h0, ok, flt}, 32'h1);
			// four edges pass during the two accesses
			chk(u_periph.ticks[i] - t0, 32'h4);
			chk(u_periph.ticks[(i + 1) % 12] - t1, 32'h0);
		end
		u_periph.access(4'hf, ok, flt);
		chk({30'h0, ok, flt}, 32'h1);
		$display("test unit_gates done");
		wr32(scg_pkg::OFS_IRQ_CLEAR, 32'h3);
		rd32(scg_pkg::OFS_IRQ_STATUS, rd);
		chk(rd, 32'h0);
		run_gate <= 32'h0000_0100;
		wr32(scg_pkg::OFS_GATE_CTRL, 32'h0);
		cyc(2);
		chk({20'h0, en_q}, 32'h0000_0020);
		// the switch to the run word changed the enables, so only the change event is pending
		rd32(scg_pkg::OFS_IRQ_STATUS, rd);
		chk(rd, 32'h2);
		wr32(scg_pkg::OFS_GATE_CTRL, 32'h1);
		sleep_active <= 1'b0;
		cyc(2);
		chk({20'h0, en_q}, 32'h0000_0020);
		sleep_active <= 1'b1;
		cyc(2);
		chk({20'h0, en_q}, 32'h0000_0800);
		$display("test mode_select done");
		wr32(scg_pkg::OFS_IRQ_CLEAR, 32'h3);
		wr32(scg_pkg::OFS_IRQ_ENABLE, 32'h1);
		cyc(1);
		chk({31'h0, irq_q}, 32'h0);
		u_periph.access(4'h0, ok, flt);
		cyc(2);
		chk({31'h0, irq_q}, 32'h1);
		rd32(scg_pkg::OFS_IRQ_STATUS, rd);
		chk(rd & 32'h1, 32'h1);
		wr32(scg_pkg::OFS_IRQ_ENABLE, 32'h0);
		cyc(2);
		chk({31'h0, irq_q}, 32'h0);
		wr32(scg_pkg::OFS_IRQ_ENABLE, 32'h1);
		cyc(2);
		chk({31'h0, irq_q}, 32'h1);
		wr32(scg_pkg::OFS_IRQ_CLEAR, 32'h1);
		cyc(2);
		chk({31'h0, irq_q}, 32'h0);
		rd32(scg_pkg::OFS_IRQ_CLEAR, rd);
		chk(rd, 32'h0);
		rd32(12'h200, rd);
		chk(rd, 32'h0);
		$display("test interrupt done");
		rst_n <= 1'b0;
		cyc(2);
		rst_n <= 1'b1;
		rd32(scg_pkg::OFS_SLEEP_GATE, rd);
		chk(rd, 32'h0000_0000);
		$display("test second_reset done");
		end_of_test();
	end
endmodule
